// ==== logic/ettc_top.sv ====
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - two trigger outputs, one per event line, related by the trigger mode
// - each line compares its conditions with every observed transaction while running
// - a match feeds the counting stage when set, else fires the trigger at once
// - pass counter fires on the configured number of matches, on the first match when set to zero
// - separate mode: each line fires on its own conditions alone
// - joint mode: line one fires only with line two address and type matching too
// - sequential freeze arms like sequential enable, line one freezes the trace
// - a frozen trace stops storing and keeps its contents
// - freeze select bit picks which trigger freezes the trace, outside sequential freeze
// - trace stores running transactions, up to 128 entries
// - only transactions of the selected bus type are stored
// - timer counts run time in microseconds or milliseconds
// - sequential enable: line one arms line two, line two re-arms line one
// - delay counter holds a trigger for a set number of chosen units
// - bus type is memory/io, read/write and instruction fetch
// - with break enabled a trigger raises a halt request
module ettc_top (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic obs_strobe,
    input wire logic [15:0] obs_addr,
    input wire logic [7:0] obs_data,
    input wire logic obs_mio,
    input wire logic obs_rw,
    input wire logic obs_fetch,
    input wire logic emu_clk_tick,
    output logic first_event_line,
    output logic second_event_line,
    output logic halt_req,
    output logic trace_frozen
);
    localparam int SW = 29;
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    logic stb_d_r;
    logic tick_d_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
            stb_d_r <= 1'b0;
            tick_d_r <= 1'b0;
        end else begin
            sync1_r <= {emu_clk_tick, obs_strobe, obs_mio, obs_rw, obs_fetch, obs_data,
                        obs_addr};
            sync2_r <= sync1_r;
            stb_d_r <= sync2_r[27];
            tick_d_r <= sync2_r[28];
        end
    end
    logic txn_stb;
    logic emu_tick;
    logic [2:0] btype;
    logic [7:0] t_data;
    logic [15:0] t_addr;
    // rising edges and transaction fields
    assign txn_stb = sync2_r[27] && !stb_d_r;
    assign emu_tick = sync2_r[28] && !tick_d_r;
    assign btype = sync2_r[26:24];
    assign t_data = sync2_r[23:16];
    assign t_addr = sync2_r[15:0];
    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave
    ettc_pkg::ettc_bus_t bus_st_r;
    ettc_pkg::ettc_bus_t bus_nxt;
    logic [5:0] rd_addr_r;
    logic [5:0] wr_addr_r;
    logic wr_pend_r;
    logic [31:0] rd_mux;
    logic ap_valid;
    logic ap_read;
    logic wr_en;
    assign ap_valid = hsel && hready && htrans[1] && (bus_st_r == ettc_pkg::ETTC_BUS_IDLE);
    assign ap_read = ap_valid && !hwrite;
    assign wr_en = wr_pend_r;
    always_comb begin
        case (bus_st_r)
            ettc_pkg::ETTC_BUS_IDLE: begin
                bus_nxt = ap_read ? ettc_pkg::ETTC_BUS_RD1 : ettc_pkg::ETTC_BUS_IDLE;
            end
            ettc_pkg::ETTC_BUS_RD1: begin
                bus_nxt = ettc_pkg::ETTC_BUS_RD2;
            end
            default: begin
                bus_nxt = ettc_pkg::ETTC_BUS_IDLE;
            end
        endcase
    end
    // reads wait two cycles so trace data is fresh
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_st_r <= ettc_pkg::ETTC_BUS_IDLE;
            hreadyout <= 1'b1;
            hrdata <= '0;
            rd_addr_r <= '0;
            wr_addr_r <= '0;
            wr_pend_r <= 1'b0;
        end else begin
            bus_st_r <= bus_nxt;
            hreadyout <= (bus_nxt == ettc_pkg::ETTC_BUS_IDLE);
            wr_pend_r <= ap_valid && hwrite;
            if (ap_valid) begin
                rd_addr_r <= haddr[5:0];
                wr_addr_r <= haddr[5:0];
            end
            if (bus_st_r == ettc_pkg::ETTC_BUS_RD2) begin
                hrdata <= rd_mux;
            end
        end
    end
    assign hresp = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [15:0] ctrl_r;
    logic [15:0] ev_addr_r [2];
    logic [15:0] ev_cond_r [2];
    logic [15:0] ev_cnt_r [2];
    logic [5:0] tsel_r;
    logic [6:0] tidx_r;
    logic clr;
    assign clr = wr_en && (wr_addr_r == ettc_pkg::OFS_CTRL) && hwdata[ettc_pkg::CTRL_CLR];
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= ettc_pkg::CTRL_RST;
            ev_addr_r <= '{ettc_pkg::CFG_RST, ettc_pkg::CFG_RST};
            ev_cond_r <= '{ettc_pkg::CFG_RST, ettc_pkg::CFG_RST};
            ev_cnt_r <= '{ettc_pkg::CFG_RST, ettc_pkg::CFG_RST};
            tsel_r <= '0;
            tidx_r <= '0;
        end else if (wr_en) begin
            case (wr_addr_r)
                ettc_pkg::OFS_CTRL: ctrl_r <= hwdata[15:0] & ~16'h0020;
                ettc_pkg::OFS_EV1_ADDR: ev_addr_r[0] <= hwdata[15:0];
                ettc_pkg::OFS_EV1_COND: ev_cond_r[0] <= hwdata[15:0];
                ettc_pkg::OFS_EV1_CNT: ev_cnt_r[0] <= hwdata[15:0];
                ettc_pkg::OFS_EV2_ADDR: ev_addr_r[1] <= hwdata[15:0];
                ettc_pkg::OFS_EV2_COND: ev_cond_r[1] <= hwdata[15:0];
                ettc_pkg::OFS_EV2_CNT: ev_cnt_r[1] <= hwdata[15:0];
                ettc_pkg::OFS_TSEL: tsel_r <= hwdata[5:0];
                ettc_pkg::OFS_TIDX: tidx_r <= hwdata[6:0];
                default: ;
            endcase
        end
    end
    logic [1:0] mode;
    logic run;
    assign mode = ctrl_r[ettc_pkg::CTRL_MODE_LO +: 2];
    assign run = ctrl_r[ettc_pkg::CTRL_RUN];
    ////////////////////////////////////////////////////////////////////////
    // time base and run timer
    logic [4:0] presc_r;
    logic [9:0] ms_cnt_r;
    logic [31:0] timer_r;
    logic us_tick;
    logic ms_tick;
    assign us_tick = (presc_r == 5'(ettc_pkg::US_CYC - 1));
    assign ms_tick = us_tick && (ms_cnt_r == 10'(ettc_pkg::MS_US - 1));
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            presc_r <= '0;
            ms_cnt_r <= '0;
            timer_r <= '0;
        end else begin
            presc_r <= us_tick ? 5'h00 : presc_r + 5'h01;
            if (us_tick) begin
                ms_cnt_r <= ms_tick ? 10'h000 : ms_cnt_r + 10'h001;
            end
            if (clr) begin
                timer_r <= '0;
            end else if (run && !halt_req
                && (ctrl_r[ettc_pkg::CTRL_TUNIT] ? ms_tick : us_tick)) begin
                timer_r <= timer_r + 32'h0000_0001;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // event comparators and counting stages
    ettc_pkg::ettc_arm_t arm_st_r;
    logic [1:0] full_m;
    logic [1:0] ab_m;
    logic [1:0] hit;
    logic [1:0] fire;
    logic [7:0] pass_cnt_r [2];
    logic [7:0] dly_cnt_r [2];
    logic [1:0] dly_act_r;
    logic [1:0] seen_r;
    logic dly_tick;
    logic seq;
    assign seq = (mode == ettc_pkg::ETTC_SEQ_ENABLE) || (mode == ettc_pkg::ETTC_SEQ_FREEZE);
    assign dly_tick = ctrl_r[ettc_pkg::CTRL_DUNIT] ? us_tick : emu_tick;
    ettc_evt_cmp u_cmp1 (
        .addr(t_addr),
        .data(t_data),
        .btype(btype),
        .cfg_addr(ev_addr_r[0]),
        .cfg_cond(ev_cond_r[0]),
        .full_match(full_m[0]),
        .addr_type_match(ab_m[0])
    );
    ettc_evt_cmp u_cmp2 (
        .addr(t_addr),
        .data(t_data),
        .btype(btype),
        .cfg_addr(ev_addr_r[1]),
        .cfg_cond(ev_cond_r[1]),
        .full_match(full_m[1]),
        .addr_type_match(ab_m[1])
    );
    // qualified match, then pass and delay decisions per line
    logic [1:0] armed;
    logic [1:0] qual;
    assign armed[0] = !seq || (arm_st_r == ettc_pkg::ETTC_ARM_FIRST);
    assign armed[1] = !seq || (arm_st_r == ettc_pkg::ETTC_ARM_SECOND);
    assign qual[0] = (mode == ettc_pkg::ETTC_JOINT) ? (full_m[0] && ab_m[1]) : full_m[0];
    assign qual[1] = full_m[1];
    for (genvar i = 0; i < 2; i++) begin : g_line
        logic m;
        logic [7:0] pass_cfg;
        logic [7:0] dly_cfg;
        assign m = run && txn_stb && armed[i] && qual[i] && !dly_act_r[i];
        assign pass_cfg = ev_cnt_r[i][7:0];
        assign dly_cfg = ev_cnt_r[i][15:8];
        assign hit[i] = m && ((pass_cnt_r[i] + 8'h01) >= pass_cfg);
        assign fire[i] = (hit[i] && (dly_cfg == 8'h00))
            || (dly_act_r[i] && dly_tick && (dly_cnt_r[i] == 8'h01));
    end
    // pass and delay counters
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pass_cnt_r <= '{8'h00, 8'h00};
            dly_cnt_r <= '{8'h00, 8'h00};
            dly_act_r <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (clr) begin
                    pass_cnt_r[i] <= 8'h00;
                    dly_act_r[i] <= 1'b0;
                end else if (hit[i]) begin
                    pass_cnt_r[i] <= 8'h00;
                    dly_cnt_r[i] <= ev_cnt_r[i][15:8];
                    dly_act_r[i] <= (ev_cnt_r[i][15:8] != 8'h00);
                end else if (run && txn_stb && armed[i] && qual[i] && !dly_act_r[i]) begin
                    pass_cnt_r[i] <= pass_cnt_r[i] + 8'h01;
                end else if (dly_act_r[i] && dly_tick) begin
                    dly_cnt_r[i] <= dly_cnt_r[i] - 8'h01;
                    dly_act_r[i] <= (dly_cnt_r[i] != 8'h01);
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // arming, triggers, freeze and halt
    logic frz_src;
    assign frz_src = (mode == ettc_pkg::ETTC_SEQ_FREEZE) ? fire[0]
        : fire[ctrl_r[ettc_pkg::CTRL_FRZ_SEL]];
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            arm_st_r <= ettc_pkg::ETTC_ARM_FIRST;
            first_event_line <= 1'b0;
            second_event_line <= 1'b0;
            seen_r <= '0;
            trace_frozen <= 1'b0;
            halt_req <= 1'b0;
        end else begin
            first_event_line <= fire[0];
            second_event_line <= fire[1];
            seen_r <= clr ? fire : (seen_r | fire);
            if (clr || !seq) begin
                arm_st_r <= ettc_pkg::ETTC_ARM_FIRST;
            end else if (fire[0]) begin
                arm_st_r <= ettc_pkg::ETTC_ARM_SECOND;
            end else if (fire[1]) begin
                arm_st_r <= ettc_pkg::ETTC_ARM_FIRST;
            end
            trace_frozen <= frz_src || (trace_frozen && !clr);
            halt_req <= (ctrl_r[ettc_pkg::CTRL_BRK] && |fire) || (halt_req && !clr);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // trace capture
    logic [6:0] wp_r;
    logic [7:0] fill_r;
    logic t_we;
    logic [ettc_pkg::TRACE_W-1:0] t_rdata;
    assign t_we = run && !trace_frozen && txn_stb
        && ettc_pkg::type_ok(btype, tsel_r[2:0], tsel_r[5:3]);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            fill_r <= '0;
        end else if (clr) begin
            wp_r <= '0;
            fill_r <= '0;
        end else if (t_we) begin
            wp_r <= wp_r + 7'h01;
            fill_r <= (fill_r == 8'(ettc_pkg::TRACE_DEPTH)) ? fill_r : fill_r + 8'h01;
        end
    end
    ettc_trace_mem u_mem (
        .clock(clock),
        .rst_n(rst_n),
        .we(t_we),
        .waddr(wp_r),
        .wdata({btype, t_data, t_addr}),
        .raddr(tidx_r),
        .rdata(t_rdata)
    );
    ////////////////////////////////////////////////////////////////////////
    // read data selection
    logic [31:0] status;
    assign status = {9'h000, wp_r, fill_r, 2'h0, arm_st_r, 1'b0, halt_req, trace_frozen,
                     seen_r};
    always_comb begin
        case (rd_addr_r)
            ettc_pkg::OFS_CTRL: rd_mux = {16'h0000, ctrl_r};
            ettc_pkg::OFS_EV1_ADDR: rd_mux = {16'h0000, ev_addr_r[0]};
            ettc_pkg::OFS_EV1_COND: rd_mux = {16'h0000, ev_cond_r[0]};
            ettc_pkg::OFS_EV1_CNT: rd_mux = {16'h0000, ev_cnt_r[0]};
            ettc_pkg::OFS_EV2_ADDR: rd_mux = {16'h0000, ev_addr_r[1]};
            ettc_pkg::OFS_EV2_COND: rd_mux = {16'h0000, ev_cond_r[1]};
            ettc_pkg::OFS_EV2_CNT: rd_mux = {16'h0000, ev_cnt_r[1]};
            ettc_pkg::OFS_TSEL: rd_mux = {26'h0000000, tsel_r};
            ettc_pkg::OFS_STATUS: rd_mux = status;
            ettc_pkg::OFS_TIMER: rd_mux = timer_r;
            ettc_pkg::OFS_TIDX: rd_mux = {25'h0000000, tidx_r};
            ettc_pkg::OFS_TDATA: rd_mux = {5'h00, t_rdata};
            default: rd_mux = 32'h0000_0000;
        endcase
    end
endmodule
`default_nettype wire

// ==== logic/ettc_pkg.sv ====
package ettc_pkg;
    // register byte offsets
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_EV1_ADDR = 6'h04;
    localparam logic [5:0] OFS_EV1_COND = 6'h08;
    localparam logic [5:0] OFS_EV1_CNT = 6'h0C;
    localparam logic [5:0] OFS_EV2_ADDR = 6'h10;
    localparam logic [5:0] OFS_EV2_COND = 6'h14;
    localparam logic [5:0] OFS_EV2_CNT = 6'h18;
    localparam logic [5:0] OFS_TSEL = 6'h1C;
    localparam logic [5:0] OFS_STATUS = 6'h20;
    localparam logic [5:0] OFS_TIMER = 6'h24;
    localparam logic [5:0] OFS_TIDX = 6'h28;
    localparam logic [5:0] OFS_TDATA = 6'h2C;
    // control field positions
    localparam int CTRL_MODE_LO = 0;
    localparam int CTRL_BRK = 2;
    localparam int CTRL_FRZ_SEL = 3;
    localparam int CTRL_RUN = 4;
    localparam int CTRL_CLR = 5;
    localparam int CTRL_TUNIT = 6;
    localparam int CTRL_DUNIT = 7;
    // condition field positions
    localparam int COND_TYPE_LO = 8;
    localparam int COND_TCARE_LO = 11;
    localparam int COND_DCARE = 14;
    localparam int COND_ACARE = 15;
    // reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] CFG_RST = 16'h0000;
    // time base: 1 us from the 40 ns clock, 1 ms from 1000 us
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_US_NS = 1000;
    localparam int US_CYC = TICK_US_NS / CLK_PERIOD_NS;
    localparam int MS_US = 1000;
    // trace store geometry
    localparam int TRACE_DEPTH = 128;
    localparam int TRACE_AW = 7;
    localparam int TRACE_W = 27;
    // trigger relation, gray ordered
    typedef enum logic [1:0] {
        ETTC_SEPARATE = 2'b00,
        ETTC_JOINT = 2'b01,
        ETTC_SEQ_ENABLE = 2'b11,
        ETTC_SEQ_FREEZE = 2'b10
    } ettc_mode_t;
    typedef enum logic [1:0] {
        ETTC_BUS_IDLE = 2'b00,
        ETTC_BUS_RD1 = 2'b01,
        ETTC_BUS_RD2 = 2'b11
    } ettc_bus_t;
    typedef enum logic {
        ETTC_ARM_FIRST = 1'b0,
        ETTC_ARM_SECOND = 1'b1
    } ettc_arm_t;
    // bus type {mio, rw, fetch} against wanted value under care mask
    function automatic logic type_ok(input logic [2:0] t, input logic [2:0] want,
                                     input logic [2:0] care);
        type_ok = ((t ^ want) & care) == 3'h0;
    endfunction
endpackage

// ==== logic/ettc_evt_cmp.sv ====
`timescale 1ns/100ps
`default_nettype none
module ettc_evt_cmp (
    input wire logic [15:0] addr,
    input wire logic [7:0] data,
    input wire logic [2:0] btype,
    input wire logic [15:0] cfg_addr,
    input wire logic [15:0] cfg_cond,
    output logic full_match,
    output logic addr_type_match
);
    logic addr_ok;
    logic data_ok;
    logic typ_ok;
    // each condition passes when its care bit is off
    assign addr_ok = !cfg_cond[ettc_pkg::COND_ACARE] || (addr == cfg_addr);
    assign data_ok = !cfg_cond[ettc_pkg::COND_DCARE] || (data == cfg_cond[7:0]);
    assign typ_ok = ettc_pkg::type_ok(btype,
        cfg_cond[ettc_pkg::COND_TYPE_LO +: 3], cfg_cond[ettc_pkg::COND_TCARE_LO +: 3]);
    assign full_match = addr_ok && data_ok && typ_ok;
    assign addr_type_match = addr_ok && typ_ok;
endmodule
`default_nettype wire

// ==== logic/ettc_trace_mem.sv ====
`timescale 1ns/100ps
`default_nettype none
module ettc_trace_mem (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic we,
    input wire logic [ettc_pkg::TRACE_AW-1:0] waddr,
    input wire logic [ettc_pkg::TRACE_W-1:0] wdata,
    input wire logic [ettc_pkg::TRACE_AW-1:0] raddr,
    output logic [ettc_pkg::TRACE_W-1:0] rdata
);
    logic [ettc_pkg::TRACE_W-1:0] mem [ettc_pkg::TRACE_DEPTH];
    // storage array, no reset
    always_ff @(posedge clock) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end
    // registered read port
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// ==== testbench/ettc_top_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module ettc_top_sva (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic first_event_line,
    input wire logic second_event_line,
    input wire logic halt_req,
    input wire logic trace_frozen
);
    logic rd_go;
    logic wr_go;
    logic ctrl_wr;
    logic [1:0] quiet_r;
    logic [1:0] quiet_nxt;
    // accepted bus requests
    assign rd_go = hsel && hready && htrans[1] && !hwrite;
    assign wr_go = hsel && hready && htrans[1] && hwrite;
    assign ctrl_wr = wr_go && haddr[5:0] == ettc_pkg::OFS_CTRL;
    assign quiet_nxt = ctrl_wr ? 2'h3 : (quiet_r != 2'h0 ? quiet_r - 2'h1 : 2'h0);
    // window after a control write in which a clear may land
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            quiet_r <= 2'h0;
        end else begin
            quiet_r <= quiet_nxt;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    AST_PULSE_ONE: assert property (first_event_line |=> !first_event_line)
        else $error("line one trigger wider than one cycle");
    AST_PULSE_TWO: assert property (second_event_line |=> !second_event_line)
        else $error("line two trigger wider than one cycle");
    AST_FRZ_CAUSE: assert property ($rose(trace_frozen) |-> first_event_line ||
        second_event_line || $past(first_event_line || second_event_line))
        else $error("trace froze without a trigger");
    AST_HALT_CAUSE: assert property ($rose(halt_req) |-> first_event_line ||
        second_event_line || $past(first_event_line || second_event_line))
        else $error("halt raised without a trigger");
    AST_FRZ_KEEP: assert property (trace_frozen && quiet_r == 2'h0 && !ctrl_wr |=> trace_frozen)
        else $error("frozen trace released without a clear");
    AST_HALT_KEEP: assert property (halt_req && quiet_r == 2'h0 && !ctrl_wr |=> halt_req)
        else $error("halt dropped without a clear");
    AST_RD_WAIT: assert property (rd_go |=> !hreadyout [*2] ##1 hreadyout)
        else $error("read data phase not two wait cycles");
    AST_WR_ZERO: assert property (wr_go |=> hreadyout)
        else $error("write data phase stalled");
    cover property ($rose(trace_frozen));
    cover property ($rose(halt_req));
    cover property (first_event_line && second_event_line);
    cover property (rd_go);
endmodule
bind ettc_top ettc_top_sva u_sva (.*);
`default_nettype wire

// ==== testbench/ettc_obs_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module ettc_obs_model (
    input wire logic clock,
    input wire logic dbg_on,
    output logic obs_strobe,
    output logic [15:0] obs_addr,
    output logic [7:0] obs_data,
    output logic obs_mio,
    output logic obs_rw,
    output logic obs_fetch,
    output logic emu_clk_tick
);
    // idle bus at start
    initial begin
        obs_strobe = 1'h0;
        obs_addr = 16'h0;
        obs_data = 8'h0;
        {obs_mio, obs_rw, obs_fetch} = 3'h0;
        emu_clk_tick = 1'h0;
    end
    // emulator clock runs free, 20 cycles a period
    always begin
        repeat (10) @(posedge clock);
        emu_clk_tick <= ~emu_clk_tick;
    end
    // one machine cycle; debug control adds a wait state
    task automatic txn(input logic [15:0] a, input logic [7:0] d, input logic [2:0] t);
        obs_addr <= a;
        obs_data <= d;
        {obs_mio, obs_rw, obs_fetch} <= t;
        @(posedge clock);
        obs_strobe <= 1'h1;
        repeat (dbg_on ? 5 : 4) @(posedge clock);
        obs_strobe <= 1'h0;
        @(posedge clock);
        // released lines flip so no stale value looks valid
        obs_addr <= ~a;
        obs_data <= ~d;
        repeat (3) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// ==== testbench/ettc_top_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_total++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module ettc_top_tb_top;
    localparam int A1 = 16'h1234;
    localparam int T2 = 3'h5;
    logic clock = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, dbg_on = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp, obs_strobe, obs_mio, obs_rw, obs_fetch, emu_clk_tick;
    logic [15:0] obs_addr;
    logic [7:0] obs_data;
    logic first_event_line, second_event_line, halt_req, trace_frozen;
    int err_total = 0, checked = 0, seed = 38, p1c = 0, p2c = 0;
    int md, pp, brk, fs, a2, tt, tc, c1, n1, n2, arm, sequential_freeze_mode, hlt, s1, s2, wp, fill;
    int mem [128];
    assign hready = hreadyout;
    ettc_top dut (.*);
    ettc_obs_model obs (.*);
    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        forever #20 clock = ~clock;
    end
    initial begin
        repeat (100000) @(posedge clock);
        err_total++;
        wrap_up();
    end
    // trigger pulse counters
    always @(posedge clock) begin
        if (first_event_line === 1'h1) p1c++;
        if (second_event_line === 1'h1) p2c++;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic do_reset;
        rst_n <= 1'h0;
        repeat (2) @(posedge clock);
        rst_n <= 1'h1;
        @(posedge clock);
    endtask
    // single word transfer, waits for hready in both phases
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int k;
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {26'h0, a};
        hwrite <= w;
        k = 0;
        do begin @(posedge clock); k++; end while (hreadyout !== 1'h1 && k < 40);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge clock); k++; end while (hreadyout !== 1'h1 && k < 80);
        r = hrdata;
        if (k >= 80) begin err_total++; wrap_up(); end
    endtask
    // reference of one observed transaction
    task automatic ref_txn(input int a, d, t);
        bit m1, m2, f1;
        m2 = a == a2 && t == T2;
        m1 = a == A1 && (md != ettc_pkg::ETTC_JOINT || m2);
        if (md[1]) begin m1 = m1 && arm == 0; m2 = m2 && arm == 1; end
        f1 = 0;
        if (m1) begin c1++; if (c1 >= pp) begin c1 = 0; f1 = 1; end end
        if (!sequential_freeze_mode && ((t ^ tt) & tc) == 0) begin
            mem[wp] = t << 24 | d << 16 | a;
            wp = (wp + 1) % 128;
            if (fill < 128) fill++;
        end
        if (f1) begin n1++; s1 = 1; end
        if (m2) begin n2++; s2 = 1; end
        if (md[1]) arm = f1 ? 1 : m2 ? 0 : arm;
        if ((f1 || m2) && brk) hlt = 1;
        if (md == ettc_pkg::ETTC_SEQ_FREEZE ? f1 : fs ? m2 : f1) sequential_freeze_mode = 1;
    endtask
    // configure, run random traffic, compare triggers, status and trace
    task automatic phase(input int m, p, b, f, x, y, z, n, hit);
        logic [31:0] r;
        int a, d, t, k;
        md = m; pp = p; brk = b; fs = f; a2 = x; tt = y; tc = z;
        {c1, n1, n2, arm, sequential_freeze_mode, hlt, s1, s2, wp, fill} = 0;
        do_reset();
        p1c = 0;
        p2c = 0;
        dbg_on <= b[0];
        bus(1, ettc_pkg::OFS_EV1_ADDR, A1, r);
        bus(1, ettc_pkg::OFS_EV1_COND, 32'h8000, r);
        bus(1, ettc_pkg::OFS_EV1_CNT, p, r);
        bus(1, ettc_pkg::OFS_EV2_ADDR, x, r);
        bus(1, ettc_pkg::OFS_EV2_COND, 32'hB800 | T2 << 8, r);
        bus(1, ettc_pkg::OFS_EV2_CNT, 32'h1, r);
        bus(1, ettc_pkg::OFS_TSEL, z << 3 | y, r);
        bus(1, ettc_pkg::OFS_CTRL, m | b << 2 | f << 3 | 32'h10, r);
        for (k = 0; k < n; k++) begin
            a = $random(seed);
            d = $random(seed) & 8'hFF;
            t = $random(seed) & 3'h7;
            a = !hit ? a & 16'hFFFF : (a & 2'h3) == 0 ? A1 : (a & 2'h3) == 1 ? x : a & 16'hFFFF;
            obs.txn(a[15:0], d[7:0], t[2:0]);
            ref_txn(a, d, t);
        end
        repeat (8) @(posedge clock);
        `CHK("line_one_pulses", n1, p1c)
        `CHK("line_two_pulses", n2, p2c)
        `CHK("frozen", sequential_freeze_mode, trace_frozen)
        `CHK("halt", hlt, halt_req)
        bus(0, ettc_pkg::OFS_STATUS, 32'h0, r);
        `CHK("status", wp << 16 | fill << 8 | arm << 5 | hlt << 3 | sequential_freeze_mode << 2 | s2 << 1 | s1, r)
        for (k = 0; k < fill; k++) begin
            bus(1, ettc_pkg::OFS_TIDX, k, r);
            bus(0, ettc_pkg::OFS_TDATA, 32'h0, r);
            `CHK("trace_entry", mem[k], r)
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin : main
        logic [31:0] r;
        int k;
        do_reset();
        bus(1, 6'h3C, 32'hFFFFFFFF, r);
        bus(1, ettc_pkg::OFS_STATUS, 32'hFFFFFFFF, r);
        for (k = 0; k < 16; k++) begin
            if (k != 11) begin
                bus(0, 6'(k * 4), 32'h0, r);
                `CHK("reset_value", 0, r)
            end
        end
        phase(ettc_pkg::ETTC_SEPARATE, 2, 0, 1, 16'h2222, 5, 7, 40, 1);
        phase(ettc_pkg::ETTC_JOINT, 1, 0, 1, A1, 0, 0, 30, 1);
        phase(ettc_pkg::ETTC_SEQ_ENABLE, 1, 0, 0, 16'h2222, 0, 0, 30, 1);
        phase(ettc_pkg::ETTC_SEQ_FREEZE, 1, 1, 1, 16'h2222, 0, 0, 30, 1);
        bus(1, ettc_pkg::OFS_CTRL, 32'h30, r);
        @(posedge clock);
        `CHK("cleared", 0, {halt_req, trace_frozen})
        phase(ettc_pkg::ETTC_SEPARATE, 1, 0, 1, 16'h2222, 0, 0, 140, 0);
        // delayed trigger: two emulator clock units
        do_reset();
        bus(1, ettc_pkg::OFS_EV1_ADDR, A1, r);
        bus(1, ettc_pkg::OFS_EV1_COND, 32'h8000, r);
        bus(1, ettc_pkg::OFS_EV1_CNT, 32'h0201, r);
        bus(1, ettc_pkg::OFS_CTRL, 32'h10, r);
        p1c = 0;
        obs.txn(A1[15:0], 8'h0, 3'h0);
        `CHK("delay_hold", 0, p1c)
        repeat (80) @(posedge clock);
        `CHK("delay_fire", 1, p1c)
        // run timer in both units
        do_reset();
        bus(1, ettc_pkg::OFS_CTRL, 32'h10, r);
        repeat (250) @(posedge clock);
        bus(0, ettc_pkg::OFS_TIMER, 32'h0, r);
        `CHK("timer_us", 1, r >= 9 && r <= 11)
        do_reset();
        bus(1, ettc_pkg::OFS_CTRL, 32'h50, r);
        repeat (26000) @(posedge clock);
        bus(0, ettc_pkg::OFS_TIMER, 32'h0, r);
        `CHK("timer_ms", 1, r)
        wrap_up();
    end
endmodule
`default_nettype wire
